// *** nii_host.v ***
// host controller: power-up wait, reset, id, parameter and unique id reads
`timescale 1ns/1ps
`default_nettype none
`include "nii_consts.vh"
module nii_host #(
  parameter PWR_WAIT_CYC = `NII_PWR_WAIT_CYC,
  parameter RST_MAX_CYC = `NII_RST_MAX_CYC,
  parameter FIFO_DEPTH = 16
) (
  input wire ref_clk, // 200 MHz clock
  input wire rst, // async reset, high
  input wire cmd_valid, // start an operation
  input wire [2:0] cmd_op, // operation code
  input wire [15:0] cmd_len, // bytes to read back
  input wire [15:0] cmd_col, // column for random data read
  output reg cmd_ready, // idle and initialised
  output reg init_done, // first reset completed
  output reg op_error, // busy exceeded limit
  output wire [7:0] rd_data, // read-back byte
  output wire rd_valid, // read-back byte present
  input wire rd_ready, // user takes byte
  output reg chip_select_n, // target select
  output reg command_latch_en, // command cycle
  output reg address_latch_en, // address cycle
  output reg write_strobe_n, // write strobe
  output reg read_strobe_n, // read strobe
  output reg write_protect_n, // write protect
  output reg [7:0] io_out, // bus drive value
  output reg io_oe, // bus drive enable
  input wire [7:0] io_in, // bus sample
  input wire ready_busy_n // ready/busy pin
);
  localparam S_PWR = 9'h001;
  localparam S_IDLE = 9'h002;
  localparam S_CMD = 9'h004;
  localparam S_ADDR = 9'h008;
  localparam S_CMD2 = 9'h010;
  localparam S_WAIT = 9'h020;
  localparam S_READ = 9'h040;
  localparam S_PUSH = 9'h080;
  localparam S_END = 9'h100;
  reg [8:0] st_q;
  reg [1:0] rb_sync_q;
  reg [7:0] io_s1_q;
  reg [7:0] io_s2_q;
  reg [31:0] cnt_q;
  reg [3:0] ph_q;
  reg [2:0] op_q;
  reg [15:0] left_q;
  reg [15:0] col_q;
  reg [1:0] addr_n_q;
  reg [7:0] byte_q;
  reg busy_seen_q;
  reg init_q;
  wire fifo_in_ready;
  wire rb = rb_sync_q[1];

  nii_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_data(byte_q),
    .in_valid(st_q == S_PUSH),
    .in_ready(fifo_in_ready),
    .out_data(rd_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );

  // two-stage sync for pins; bus sample second stage only read
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rb_sync_q <= 2'b00;
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
    end else begin
      rb_sync_q <= {rb_sync_q[0], ready_busy_n};
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  // command byte for the first cycle of each op; enhanced status is never sent
  // see [RULE16]
  function [7:0] first_cmd;
    input [2:0] op;
    begin
      case (op)
        `NII_OP_ID: first_cmd = `NII_CMD_READ_ID;
        `NII_OP_SIG: first_cmd = `NII_CMD_READ_ID;
        `NII_OP_PARAM: first_cmd = `NII_CMD_PARAM;
        `NII_OP_UID: first_cmd = `NII_CMD_UID;
        `NII_OP_RAND: first_cmd = `NII_CMD_RAND_1;
        `NII_OP_STATUS: first_cmd = `NII_CMD_STATUS;
        default: first_cmd = `NII_CMD_RESET;
      endcase
    end
  endfunction

  // main sequencer; strobes are held for a fixed number of cycles
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_PWR;
      cnt_q <= 32'h0000_0000;
      ph_q <= 4'h0;
      op_q <= `NII_OP_RESET;
      left_q <= 16'h0000;
      col_q <= 16'h0000;
      addr_n_q <= 2'b00;
      byte_q <= 8'h00;
      busy_seen_q <= 1'b0;
      init_q <= 1'b0;
      cmd_ready <= 1'b0;
      init_done <= 1'b0;
      op_error <= 1'b0;
      chip_select_n <= 1'b1;
      command_latch_en <= 1'b0;
      address_latch_en <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_protect_n <= 1'b0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      case (st_q)
        // hold protect low and wait out power-up, then need ready high
        S_PWR: begin
          if (cnt_q < PWR_WAIT_CYC) begin
            cnt_q <= cnt_q + 32'd1; // see [RULE2]
          end else if (rb) begin // see [RULE1]
            write_protect_n <= 1'b1;
            op_q <= `NII_OP_RESET; // see [RULE3]
            ph_q <= 4'h0;
            st_q <= S_CMD;
          end
        end
        S_IDLE: begin
          chip_select_n <= 1'b1;
          io_oe <= 1'b0;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_error <= 1'b0;
            op_q <= cmd_op;
            left_q <= cmd_len;
            col_q <= cmd_col;
            ph_q <= 4'h0;
            st_q <= S_CMD;
          end
        end
        // command latch cycle, data stable across write rise
        S_CMD: begin
          chip_select_n <= 1'b0;
          command_latch_en <= 1'b1;
          address_latch_en <= 1'b0;
          read_strobe_n <= 1'b1; // see [RULE24]
          io_oe <= 1'b1;
          io_out <= first_cmd(op_q);
          ph_q <= ph_q + 4'h1;
          write_strobe_n <= (ph_q >= 4'h1 && ph_q < 4'h4) ? 1'b0 : 1'b1;
          if (ph_q == `NII_STROBE_CYC) begin
            command_latch_en <= 1'b0;
            ph_q <= 4'h0;
            cnt_q <= 32'h0000_0000;
            busy_seen_q <= 1'b0;
            addr_n_q <= (op_q == `NII_OP_RAND) ? 2'd2 : 2'd1;
            if (op_q == `NII_OP_RESET || op_q == `NII_OP_STATUS) begin
              st_q <= (op_q == `NII_OP_RESET) ? S_WAIT : S_READ;
              left_q <= (op_q == `NII_OP_STATUS) ? 16'h0001 : left_q;
            end else begin
              st_q <= S_ADDR;
            end
          end
        end
        // address cycles: 00h/20h for reads, two column bytes for random read
        S_ADDR: begin
          address_latch_en <= 1'b1; // see [RULE25]
          io_out <= (op_q == `NII_OP_SIG) ? `NII_ADDR_SIG : // see [RULE12]
            (op_q == `NII_OP_RAND) ? ((addr_n_q == 2'd2) ? col_q[7:0] : col_q[15:8]) :
            `NII_ADDR_ID; // see [RULE11]
          ph_q <= ph_q + 4'h1;
          write_strobe_n <= (ph_q >= 4'h1 && ph_q < 4'h4) ? 1'b0 : 1'b1;
          if (ph_q == `NII_STROBE_CYC) begin
            ph_q <= 4'h0;
            addr_n_q <= addr_n_q - 2'd1;
            if (addr_n_q == 2'd1) begin
              address_latch_en <= 1'b0;
              if (op_q == `NII_OP_RAND) begin
                st_q <= S_CMD2; // see [RULE19]
              end else if (op_q == `NII_OP_PARAM || op_q == `NII_OP_UID) begin
                st_q <= S_WAIT; // see [RULE15]
              end else begin
                st_q <= S_READ;
              end
            end
          end
        end
        // second command of the random data read pair
        S_CMD2: begin
          command_latch_en <= 1'b1;
          io_out <= `NII_CMD_RAND_2;
          ph_q <= ph_q + 4'h1;
          write_strobe_n <= (ph_q >= 4'h1 && ph_q < 4'h4) ? 1'b0 : 1'b1;
          if (ph_q == `NII_STROBE_CYC) begin
            command_latch_en <= 1'b0;
            ph_q <= 4'h0;
            st_q <= S_READ;
          end
        end
        // watch busy fall then rise; bounded by the reset maximum
        S_WAIT: begin
          io_oe <= 1'b0;
          cnt_q <= cnt_q + 32'd1;
          if (!rb) begin
            busy_seen_q <= 1'b1;
          end
          if (cnt_q >= RST_MAX_CYC) begin
            op_error <= 1'b1; // see [RULE4]
            st_q <= S_END;
          end else if (rb && (busy_seen_q || cnt_q > 32'd64)) begin
            st_q <= (op_q == `NII_OP_RESET) ? S_END : S_READ;
          end
        end
        // one byte per read toggle, sampled late in the low phase
        S_READ: begin
          io_oe <= 1'b0;
          if (left_q == 16'h0000) begin
            st_q <= S_END;
          end else begin
            ph_q <= ph_q + 4'h1;
            read_strobe_n <= (ph_q < 4'h5) ? 1'b0 : 1'b1; // see [RULE20]
            if (ph_q == 4'h5) begin
              byte_q <= io_s2_q; // see [RULE26]
            end
            if (ph_q == `NII_STROBE_CYC) begin
              ph_q <= 4'h0;
              st_q <= S_PUSH;
            end
          end
        end
        // fifo back-pressure stalls further reads
        // bytes pass unaltered: crc and complement checks are the user's job
        // see [RULE18] [RULE22]
        S_PUSH: begin
          if (fifo_in_ready) begin
            left_q <= left_q - 16'h0001;
            st_q <= S_READ;
          end
        end
        S_END: begin
          chip_select_n <= 1'b1;
          read_strobe_n <= 1'b1;
          if (op_q == `NII_OP_RESET) begin
            init_q <= 1'b1;
            init_done <= 1'b1;
          end
          cmd_ready <= 1'b1;
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_PWR;
        end
      endcase
      if (st_q == S_END && !init_q && op_q != `NII_OP_RESET) begin
        cmd_ready <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** nii_consts.vh ***
// constants for the nand init, reset and identify host controller
//
// Overview of operation
// [RULE1] reset waits until ready_busy_n valid and high
// [RULE2] without watching busy, wait 100us after power
// [RULE3] first command to each target is ffh
// [RULE4] device busy at most 1ms after reset
// [RULE5] reset aborts busy read, program or erase
// [RULE6] reset clears command, data and cache registers
// [RULE7] status after reset e0h or 60h by protect
// [RULE8] device holds busy low during reset interval
// [RULE9] id, parameter, unique id only when idle
// [RULE10] read modes persist until next valid command
// [RULE11] 90h with 00h returns five identifier bytes
// [RULE12] 90h with 20h returns four signature bytes
// [RULE13] identifier byte 2 equals 90h
// [RULE14] identifier bytes 3 and 4 are 95h, 06h
// [RULE15] ech/edh busy one read, 00h resumes output
// [RULE16] host never uses 78h during parameter read
// [RULE17] at least three crc protected 256-byte copies
// [RULE18] host checks crc, moves to next copy; nii_host passes bytes unchecked and leaves this to the user
// [RULE19] 05h-e0h relocates parameter page output position
// [RULE20] unique id gives one byte per read toggle
// [RULE21] sixteen 32-byte unique id copies with complement
// [RULE22] host accepts copy when halves xor to ffh; nii_host passes bytes unchecked and leaves this to the user
// [RULE23] busy die ignores commands except status reads
// [RULE24] command latched on write rise with cle
// [RULE25] address latched on write rise with ale
// [RULE26] data driven on read strobe falling edge
// [RULE27] read modes restart from first byte
`ifndef NII_CONSTS_VH
`define NII_CONSTS_VH
`define NII_CMD_RESET 8'hff
`define NII_CMD_READ_ID 8'h90
`define NII_CMD_PARAM 8'hec
`define NII_CMD_UID 8'hed
`define NII_CMD_STATUS 8'h70
`define NII_CMD_READ_MODE 8'h00
`define NII_CMD_RAND_1 8'h05
`define NII_CMD_RAND_2 8'he0
`define NII_ADDR_ID 8'h00
`define NII_ADDR_SIG 8'h20
`define NII_ST_RDY_BIT 6
`define NII_CLK_NS 5
`define NII_PWR_WAIT_NS 100000
`define NII_PWR_WAIT_CYC ((`NII_PWR_WAIT_NS + `NII_CLK_NS - 1) / `NII_CLK_NS)
`define NII_RST_MAX_NS 1000000
`define NII_RST_MAX_CYC (`NII_RST_MAX_NS / `NII_CLK_NS)
`define NII_STROBE_CYC 6
`define NII_ID_LEN 5
`define NII_SIG_LEN 4
`define NII_PP_LEN 256
`define NII_UID_LEN 32
`define NII_OP_RESET 3'd0
`define NII_OP_ID 3'd1
`define NII_OP_SIG 3'd2
`define NII_OP_PARAM 3'd3
`define NII_OP_UID 3'd4
`define NII_OP_RAND 3'd5
`define NII_OP_STATUS 3'd6
`endif

// *** nii_fifo.v ***
// small valid/ready fifo for read-back bytes
`timescale 1ns/1ps
`default_nettype none
module nii_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // clock
  input wire rst, // async reset, high
  input wire [WIDTH-1:0] in_data, // write data
  input wire in_valid, // write request
  output wire in_ready, // not full
  output wire [WIDTH-1:0] out_data, // head word
  output wire out_valid, // not empty
  input wire out_ready // drain
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q; // words held, output register included
  reg [WIDTH-1:0] head_q;
  reg head_vld_q;
  wire push = in_valid && in_ready;
  wire pop = head_vld_q && out_ready;
  // words still in the array, beyond the one in the output register
  wire stored = (cnt_q != {{AW{1'b0}}, head_vld_q});
  wire load = stored && (!head_vld_q || out_ready);
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  // outputs come straight from registers, at the cost of one cycle of latency
  assign out_valid = head_vld_q;
  assign out_data = head_q;
  // storage and head have no reset; head_vld_q guards head_q
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (load) begin
      head_q <= mem[rd_q];
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      head_vld_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (load) begin
        rd_q <= rd_q + 1'b1;
        head_vld_q <= 1'b1;
      end else if (pop) begin
        head_vld_q <= 1'b0;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** nii_dev_model.sv ***
// behavioural nand target: reset, id, parameter page, unique id, status
`timescale 1ns/1ps
`default_nettype none
module nii_dev_model #(
  parameter MFR = 8'h3c, // arbitrary maker code
  parameter DEV = 8'h5b // arbitrary device code
) (
  input wire logic chip_select_n, // select
  input wire logic command_latch_en, // command cycle
  input wire logic address_latch_en, // address cycle
  input wire logic write_strobe_n, // write strobe
  input wire logic read_strobe_n, // read strobe
  input wire logic write_protect_n, // protect
  input wire logic [7:0] io_out, // host drive
  input wire logic io_oe, // host enable
  output logic [7:0] io_in, // resolved bus
  output logic ready_busy_n, // busy pin
  output logic proto_err // host broke order
);
  logic [7:0] cmd, mode, pm, st, dq, last;
  logic [15:0] idx, col;
  logic dv, seen, sig;
  int acnt, bt;
  event bsy;
  // released bus shows the inverse of the last value so stale data cannot pass
  assign io_in = dv ? dq : io_oe ? io_out : ~last;
  always @(io_out or dq) last = dv ? dq : io_out;
  // power-on: pin low until valid
  initial begin
    {dv, seen, proto_err, sig} = 0;
    {mode, pm, st, idx, col, acnt} = 0;
    ready_busy_n = 0;
    #300 ready_busy_n = 1;
  end
  always @(bsy) begin
    ready_busy_n = 0;
    #(bt) ready_busy_n = 1;
  end
  // command and address capture on write rise
  always @(posedge write_strobe_n) if (!chip_select_n && read_strobe_n) begin
    if (command_latch_en && !address_latch_en) begin
      // first command must be reset, and only once the pin is valid
      if (!seen && (io_in !== 8'hff || $time < 300)) proto_err = 1;
      // enhanced status is banned while a parameter page is read out
      if (mode == 8'hec && io_in == 8'h78) proto_err = 1;
      if (ready_busy_n || io_in == 8'h70) begin
        cmd = io_in;
        acnt = 0;
        case (io_in)
          8'hff: begin
            seen = 1;
            st = write_protect_n ? 8'he0 : 8'h60;
            mode = 0;
            bt = 1000;
            ->bsy;
          end
          8'h70: begin
            pm = mode;
            mode = 8'h70;
          end
          8'h00: mode = pm;
          8'he0: idx = col;
          8'h05: ;
          default: begin
            mode = io_in;
            idx = 0;
          end
        endcase
      end
    end else if (address_latch_en && !command_latch_en && ready_busy_n) begin
      acnt++;
      if (cmd == 8'h90) sig = (io_in == 8'h20);
      if (cmd == 8'hec || cmd == 8'hed) begin
        bt = 200;
        ->bsy;
      end
      if (cmd == 8'h05 && acnt == 1) col[7:0] = io_in;
      if (cmd == 8'h05 && acnt == 2) col[15:8] = io_in;
    end
  end
  // one byte per read fall, released shortly after the rise
  always @(negedge read_strobe_n)
    if (!chip_select_n && !command_latch_en && !address_latch_en && write_strobe_n) begin
    case (mode)
      8'h90: begin
        if (sig) dq = idx == 0 ? 8'h4f : idx == 1 ? 8'h4e : idx == 2 ? 8'h46 : 8'h49;
        else dq = idx == 0 ? MFR : idx == 1 ? DEV : idx == 2 ? 8'h90 : idx == 3 ? 8'h95 : 8'h06;
      end
      8'hec: dq = idx[7:0] ^ 8'ha5;
      8'hed: dq = idx[4] ? ~{4'ha, idx[3:0]} : {4'ha, idx[3:0]};
      default: dq = st;
    endcase
    dv = 1;
    idx++;
  end
  always @(posedge read_strobe_n) #2 dv = 0;
endmodule
`default_nettype wire

// *** nii_host_monitor.sv ***
// bus timing checks on the host controller pins
`timescale 1ns/1ps
`default_nettype none
module nii_host_monitor (
  input wire ref_clk, // clock
  input wire rst, // reset
  input wire cmd_ready, // idle
  input wire init_done, // first reset done
  input wire chip_select_n, // select
  input wire command_latch_en, // command cycle
  input wire address_latch_en, // address cycle
  input wire write_strobe_n, // write strobe
  input wire read_strobe_n, // read strobe
  input wire [7:0] io_out, // bus value
  input wire io_oe // bus enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_cmd_after_init: assert property (cmd_ready |-> init_done)
    else $error("ready before init");
  a_first_is_reset: assert property (command_latch_en && !init_done |-> io_out == 8'hff)
    else $error("first command not reset");
  a_init_sticky: assert property (init_done |=> init_done)
    else $error("init dropped");
  a_write_pulse: assert property ($fell(write_strobe_n) |->
    ##1 !write_strobe_n [*2] ##1 write_strobe_n) else $error("write pulse width");
  a_write_hold: assert property ($fell(write_strobe_n) |-> ##1 $stable(io_out) [*3])
    else $error("bus moved in write");
  a_write_cycle: assert property (!write_strobe_n |->
    !chip_select_n && read_strobe_n && io_oe && (command_latch_en ^ address_latch_en))
    else $error("bad write cycle");
  a_read_pulse: assert property ($fell(read_strobe_n) |->
    ##1 !read_strobe_n [*4] ##1 read_strobe_n) else $error("read pulse width");
  a_read_cycle: assert property (!read_strobe_n |->
    !io_oe && !command_latch_en && !address_latch_en && write_strobe_n && !chip_select_n)
    else $error("bad read cycle");
endmodule
bind nii_host nii_host_monitor i_nii_host_monitor (.ref_clk, .rst, .cmd_ready, .init_done,
  .chip_select_n, .command_latch_en, .address_latch_en, .write_strobe_n, .read_strobe_n,
  .io_out, .io_oe);
`default_nettype wire

// *** nii_host_tb.sv ***
// testbench for the nand init, reset and identify host
`timescale 1ns/1ps
`default_nettype none
module nii_host_tb;
  logic ref_clk, rst, cmd_valid, rd_ready;
  logic [2:0] cmd_op;
  logic [15:0] cmd_len, cmd_col;
  wire cmd_ready, init_done, op_error, rd_valid, cs_n, cle, ale, we_n, rdstb_n;
  wire wp_n, io_oe, rb_n, perr;
  wire [7:0] rd_data, io_out, io_in;
  logic [7:0] b [0:63];
  logic [7:0] idv [0:4] = '{8'h3c, 8'h5b, 8'h90, 8'h95, 8'h06};
  logic [7:0] sgv [0:3] = '{8'h4f, 8'h4e, 8'h46, 8'h49};
  int errors = 0, n_compared = 0, cyc = 0, i, t;
  nii_host #(.PWR_WAIT_CYC(20), .RST_MAX_CYC(500), .FIFO_DEPTH(16)) i_nii_host (.ref_clk, .rst,
    .cmd_valid, .cmd_op, .cmd_len, .cmd_col, .cmd_ready, .init_done, .op_error, .rd_data,
    .rd_valid, .rd_ready, .chip_select_n(cs_n), .command_latch_en(cle), .address_latch_en(ale),
    .write_strobe_n(we_n), .read_strobe_n(rdstb_n), .write_protect_n(wp_n), .io_out, .io_oe,
    .io_in, .ready_busy_n(rb_n));
  nii_dev_model #(.MFR(8'h3c), .DEV(8'h5b)) i_nii_dev_model (.chip_select_n(cs_n),
    .command_latch_en(cle), .address_latch_en(ale), .write_strobe_n(we_n),
    .read_strobe_n(rdstb_n),
    .write_protect_n(wp_n), .io_out, .io_oe, .io_in, .ready_busy_n(rb_n), .proto_err(perr));
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin errors++; summarize(); end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin errors++; $display("unexpected %s expected %h seen %h", nm, e, g); end
  endtask
  // start one operation once the host is idle
  task automatic op(input logic [2:0] o, input logic [15:0] n, input logic [15:0] c);
    do begin @(posedge ref_clk); #1; end while (cmd_ready !== 1'b1);
    @(posedge ref_clk);
    cmd_op <= o; cmd_len <= n; cmd_col <= c; cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
  endtask
  // collect n bytes, sampled mid-cycle ahead of the handshake edge
  task automatic take(input int n);
    int k;
    k = 0;
    while (k < n) begin @(negedge ref_clk); if (rd_valid === 1'b1 && rd_ready) b[k++] = rd_data; end
  endtask
  initial begin
    cmd_valid = 0; cmd_op = 0; cmd_len = 0; cmd_col = 0; rd_ready = 1; rst = 1;
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    // the host raises protect before its first reset, so status reads e0h
    op(6, 1, 0); take(1); chk("status", 8'he0, b[0]);
    $display("test init done");
    for (t = 0; t < 2; t++) begin
      op(1, 5, 0); take(5);
      for (i = 0; i < 5; i++) chk("id", idv[i], b[i]);
    end
    op(2, 4, 0); take(4);
    for (i = 0; i < 4; i++) chk("sig", sgv[i], b[i]);
    $display("test identify done");
    @(posedge ref_clk);
    rd_ready <= 0;
    op(3, 40, 0);
    repeat (400) @(posedge ref_clk);
    chk("fifo stall", 8'h01, {7'h00, rd_valid});
    rd_ready <= 1;
    take(40);
    for (i = 0; i < 40; i++) chk("param", i[7:0] ^ 8'ha5, b[i]);
    op(5, 4, 16'd260); take(4);
    for (i = 0; i < 4; i++) chk("random", (i[7:0] + 8'h04) ^ 8'ha5, b[i]);
    $display("test parameter done");
    op(4, 32, 0); take(32);
    for (i = 0; i < 16; i++) chk("uid", 8'hff, b[i] ^ b[i + 16]);
    for (i = 0; i < 16; i++) chk("uid", {4'ha, i[3:0]}, b[i]);
    $display("test unique id done");
    op(0, 0, 0); op(6, 1, 0); take(1);
    chk("status", 8'he0, b[0]);
    chk("flags", 8'h09, {4'h0, wp_n, op_error, perr, init_done});
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
